// ### frg_host.sv
// Host controller driving flash strobes, power-down and ready/busy tracking
`timescale 1ns/1ps
// Operation
// [RL1] Flash pulls ready_busy_out low on accepted alter command, high when done.
// [RL2] Ready_busy_out stays high in suspend and deep power-down.
// [RL3] Ready_busy_out is always driven, usable as an interrupt input.
// [RL4] Supply error sets supply flag plus write or erase flag.
// [RL5] Power-down mid-operation keeps busy low, then aborts into deep power-down.
// [RL6] Host reissues a full command sequence after an aborted operation.
// [RL7] Status register clears on power-off and on reset_powerdown_n low.
// [RL8] Command interface latches host writes only, not supply or select changes.
// [RL9] Command interface enters read-array at power-up and power-down exit.
// [RL10] Host writes read-array before array access after any alter operation.
// [RL11] Command write happens only with write strobe and chip select both low.
// [RL12] Array alteration needs a setup write then a confirm write.
// [RL13] With reset_powerdown_n low the flash ignores all control inputs.
// [RL14] Host waits wake delays after raising reset_powerdown_n before access.
// [RL15] Host restores read-array mode by writing the read-array code.
// [RL16] Error flags stay set until the clear-status command.
// [RL17] Ready_busy_out follows the busy state, matching the status ready bit.
module frg_host
  import frg_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire logic ready_busy_in,
  input wire logic [15:0] data_in,
  output frg_pins_s pins_out
);
  frg_state_e state_q;
  logic [7:0] cnt_q;
  logic [7:0] rd_wait_q;
  logic [7:0] wr_wait_q;
  logic pd_req_q;
  logic rb_q;
  logic done_q;
  logic abort_q;
  logic need_ra_q;
  logic cmd_pend_q;
  logic [15:0] cmd_q;
  logic [15:0] fstat_q;
  logic rd_pend_q;

  // ----------------------------------------------------------------
  // Ready/busy tracking
  // ----------------------------------------------------------------
  // Pin is always driven, so sample it directly as a level [RL3]
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      rb_q <= 1'b1;
    else
      rb_q <= ready_busy_in; // [RL1] [RL17]
  end

  // Completion is sticky; a new rising edge wins over a status read clear
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      done_q <= 1'b0;
    else if (!rb_q && ready_busy_in && state_q != FRG_PD)
      done_q <= 1'b1; // [RL1] [RL2]
    else if (rd_in && addr_in == FRG_REG_STAT)
      done_q <= 1'b0;
  end

  // Power-down while busy means the flash aborted its operation [RL5]
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      abort_q <= 1'b0;
    else if (state_q == FRG_IDLE && pd_req_q && !rb_q)
      abort_q <= 1'b1; // [RL5] [RL6]
    else if (wr_in && addr_in == FRG_REG_CMD)
      abort_q <= 1'b0; // Cleared once software reissues a sequence [RL6]
  end

  // Alter operations leave the flash out of read-array until FFH [RL10]
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      need_ra_q <= 1'b0;
    else if (state_q == FRG_WAKE)
      need_ra_q <= 1'b0; // [RL9] Power-down exit restores read-array
    else if (state_q == FRG_WSTRB && cnt_q == FRG_CNT_ZERO)
      need_ra_q <= cmd_q[7:0] != FRG_CMD_READ_ARRAY; // [RL10] [RL15]
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      pd_req_q <= 1'b0;
    else if (wr_in && addr_in == FRG_REG_CTRL)
      pd_req_q <= wdata_in[FRG_CTRL_PD];
  end

  // Command writes queue one word; a second write before issue overwrites
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cmd_q <= FRG_DATA_ZERO;
      cmd_pend_q <= 1'b0;
    end
    else if (wr_in && addr_in == FRG_REG_CMD)
    begin
      cmd_q <= wdata_in;
      cmd_pend_q <= 1'b1;
    end
    else if (state_q == FRG_IDLE && cmd_pend_q && !pd_req_q && wr_wait_q == FRG_CNT_ZERO)
      cmd_pend_q <= 1'b0;
  end

  // Flash status read request
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      rd_pend_q <= 1'b0;
    else if (rd_in && addr_in == FRG_REG_FSTAT)
      rd_pend_q <= 1'b1;
    else if (state_q == FRG_IDLE && !cmd_pend_q && !pd_req_q && rd_wait_q == FRG_CNT_ZERO)
      rd_pend_q <= 1'b0;
  end

  // Read data one cycle after the strobe; FSTAT shows last captured value
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_out <= FRG_DATA_ZERO;
    else if (rd_in)
    begin
      unique case (addr_in)
        FRG_REG_CTRL: rdata_out <= {15'h0000, pd_req_q};
        FRG_REG_CMD: rdata_out <= cmd_q;
        // Flash left out of read-array shows so software knows FFH is due [RL10]
        FRG_REG_STAT: rdata_out <= {9'h000, need_ra_q, cmd_pend_q, abort_q,
                                    wr_wait_q == FRG_CNT_ZERO, rd_wait_q == FRG_CNT_ZERO,
                                    done_q, !rb_q};
        FRG_REG_FSTAT: rdata_out <= fstat_q; // [RL4] [RL16] flags as seen
        default: rdata_out <= FRG_DATA_ZERO;
      endcase
    end
    else
      rdata_out <= FRG_DATA_ZERO;
  end

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  // Wake delays restart on each power-down exit [RL14]
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_wait_q <= 8'(FRG_WAKE_READ_CYC);
      wr_wait_q <= 8'(FRG_WAKE_WRITE_CYC);
    end
    else if (state_q == FRG_PD)
    begin
      rd_wait_q <= 8'(FRG_WAKE_READ_CYC); // [RL14]
      wr_wait_q <= 8'(FRG_WAKE_WRITE_CYC); // [RL14]
    end
    else
    begin
      if (rd_wait_q != FRG_CNT_ZERO)
        rd_wait_q <= rd_wait_q - 8'h01;
      if (wr_wait_q != FRG_CNT_ZERO)
        wr_wait_q <= wr_wait_q - 8'h01;
    end
  end

  // Strobes are only driven outside power-down, since the flash ignores them
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= FRG_PD;
      cnt_q <= FRG_CNT_ZERO;
      pins_out <= '{reset_powerdown_n: 1'b0, chip_select_n: 1'b1, write_strobe_n: 1'b1,
                    output_enable_n: 1'b1, data: FRG_DATA_ZERO, data_oe: 1'b0};
      fstat_q <= FRG_DATA_ZERO;
    end
    else
    begin
      unique case (state_q)
        FRG_IDLE:
        begin
          if (pd_req_q)
          begin
            state_q <= FRG_PD;
            pins_out.reset_powerdown_n <= 1'b0; // [RL7] [RL13] clears flash status
            fstat_q <= FRG_DATA_ZERO; // [RL7]
          end
          else if (cmd_pend_q && wr_wait_q == FRG_CNT_ZERO)
          begin
            // Setup and confirm are two separate strobed writes [RL12]
            state_q <= FRG_WSTRB;
            cnt_q <= 8'(FRG_STROBE_CYC - 1);
            pins_out.chip_select_n <= 1'b0; // [RL11]
            pins_out.write_strobe_n <= 1'b0; // [RL11] [RL8]
            pins_out.data <= cmd_q;
            pins_out.data_oe <= 1'b1;
          end
          else if (rd_pend_q && rd_wait_q == FRG_CNT_ZERO)
          begin
            state_q <= FRG_RSTRB;
            cnt_q <= 8'(FRG_STROBE_CYC - 1);
            pins_out.chip_select_n <= 1'b0;
            pins_out.output_enable_n <= 1'b0;
          end
        end
        FRG_WSTRB, FRG_RSTRB:
        begin
          if (cnt_q == FRG_CNT_ZERO)
          begin
            state_q <= FRG_IDLE;
            if (state_q == FRG_RSTRB)
              fstat_q <= data_in;
            pins_out.chip_select_n <= 1'b1;
            pins_out.write_strobe_n <= 1'b1; // Raising ends the write [RL11]
            pins_out.output_enable_n <= 1'b1;
            pins_out.data_oe <= 1'b0;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        end
        FRG_PD:
        begin
          if (!pd_req_q)
          begin
            state_q <= FRG_WAKE;
            pins_out.reset_powerdown_n <= 1'b1; // [RL9] [RL14]
          end
        end
        default:
          state_q <= FRG_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Write pulse steps: held low for the full strobe width, then released
  sequence s_we_low;
    !pins_out.write_strobe_n [*4];
  endsequence
  sequence s_we_release;
    pins_out.write_strobe_n;
  endsequence

  a_write_gated: assert property (@(posedge mclk_in) disable iff (rst_in) // [RL11]
    !pins_out.write_strobe_n |-> !pins_out.chip_select_n && pins_out.reset_powerdown_n)
    else $error("write strobe without select");
  a_wake_wait: assert property (@(posedge mclk_in) disable iff (rst_in) // [RL14]
    $rose(pins_out.write_strobe_n == 1'b0) |-> wr_wait_q == FRG_CNT_ZERO)
    else $error("write before wake delay");
  // A read strobe that beats the read wake delay would return stale data
  a_read_wake: assert property (@(posedge mclk_in) disable iff (rst_in) // [RL14]
    $fell(pins_out.output_enable_n) |-> rd_wait_q == FRG_CNT_ZERO)
    else $error("read before wake delay");
  a_pd_quiet: assert property (@(posedge mclk_in) disable iff (rst_in) // [RL13]
    !pins_out.reset_powerdown_n |-> pins_out.chip_select_n && !pins_out.data_oe)
    else $error("strobe during power-down");
  a_strobe_len: assert property (@(posedge mclk_in) disable iff (rst_in) // [RL12]
    $fell(pins_out.write_strobe_n) |-> s_we_low ##1 s_we_release)
    else $error("write strobe length wrong");
endmodule : frg_host

// ### frg_pkg.sv
// Package for the flash ready/busy and power-down host controller
package frg_pkg;
  // ----------------------------------------------------------------
  // Host register map (word offsets on the plain command port)
  // ----------------------------------------------------------------
  localparam logic [3:0] FRG_REG_CTRL = 4'h0;
  localparam logic [3:0] FRG_REG_CMD = 4'h1;
  localparam logic [3:0] FRG_REG_STAT = 4'h2;
  localparam logic [3:0] FRG_REG_FSTAT = 4'h3;
  // CTRL fields
  localparam int FRG_CTRL_PD = 0;
  // STAT fields
  localparam int FRG_ST_BUSY = 0;
  localparam int FRG_ST_DONE = 1;
  localparam int FRG_ST_RDRDY = 2;
  localparam int FRG_ST_WRRDY = 3;
  localparam int FRG_ST_ABORT = 4;
  localparam int FRG_ST_CMDPEND = 5;
  localparam int FRG_ST_NEEDRA = 6;
  // Flash status bits
  localparam int FRG_SR_READY = 7;
  localparam int FRG_SR_ERASE = 5;
  localparam int FRG_SR_WRITE = 4;
  localparam int FRG_SR_SUPPLY = 3;
  // Flash command codes
  localparam logic [7:0] FRG_CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] FRG_CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] FRG_CMD_CLEAR_STATUS = 8'h50;
  // ----------------------------------------------------------------
  // Timing (125 MHz clock)
  // ----------------------------------------------------------------
  localparam int FRG_CLK_PERIOD_PS = 8000;
  localparam int FRG_WAKE_READ_NS = 400;
  localparam int FRG_WAKE_WRITE_NS = 1000;
  localparam int FRG_WAKE_READ_CYC = (FRG_WAKE_READ_NS * 1000 + FRG_CLK_PERIOD_PS - 1)
                                     / FRG_CLK_PERIOD_PS;
  localparam int FRG_WAKE_WRITE_CYC = (FRG_WAKE_WRITE_NS * 1000 + FRG_CLK_PERIOD_PS - 1)
                                      / FRG_CLK_PERIOD_PS;
  localparam int FRG_STROBE_CYC = 4;
  localparam logic [7:0] FRG_CNT_ZERO = 8'h00;
  localparam logic [15:0] FRG_DATA_ZERO = 16'h0000;

  // Sequencer states
  typedef enum logic [2:0] {
    FRG_IDLE = 3'b000,
    FRG_WSTRB = 3'b001,
    FRG_RSTRB = 3'b010,
    FRG_PD = 3'b011,
    FRG_WAKE = 3'b100
  } frg_state_e;

  // Pins toward the flash
  typedef struct packed {
    logic reset_powerdown_n;
    logic chip_select_n;
    logic write_strobe_n;
    logic output_enable_n;
    logic [15:0] data;
    logic data_oe;
  } frg_pins_s;
endpackage : frg_pkg

// ### frg_flash_model.sv
// Behavioural flash device seen by the host controller
`timescale 1ns/1ps
module frg_flash_model
  import frg_pkg::*;
#(
  parameter int BUSY_CYC = 20,
  parameter int RST_CYC = 3,
  parameter logic [15:0] ARRAY_WORD = 16'h5a3c
)
(
  input wire logic mclk_in,
  input frg_pins_s pins_in,
  input wire logic vpp_ok_in,
  output logic ready_busy_out,
  output logic [15:0] data_out
);
  // ----------------------------------------------------------------
  // Command interface and write state machine
  // ----------------------------------------------------------------
  logic [7:0] sr_q = 8'h00;
  logic [7:0] setup_q = 8'h00;
  logic [7:0] d_q = 8'h00;
  logic stat_q = 1'b0; // Read-array mode at power-up
  logic act_q = 1'b0;
  int busy_q = 0;
  logic act;
  logic on;
  assign act = !pins_in.write_strobe_n && !pins_in.chip_select_n;
  assign on = pins_in.reset_powerdown_n;
  // Ready pin comes straight from the busy count, never floats
  assign ready_busy_out = (busy_q == 0);
  // Commands land at the end of the write pulse, only from host writes
  always_ff @(posedge mclk_in)
  begin
    act_q <= act && on;
    if (act && on)
      d_q <= pins_in.data[7:0];
    if (!on)
    begin
      // Pin low: status cleared, inputs ignored, abort after a short internal reset
      sr_q <= 8'h00;
      setup_q <= 8'h00;
      stat_q <= 1'b0;
      busy_q <= (busy_q > RST_CYC) ? RST_CYC : ((busy_q > 0) ? busy_q - 1 : 0);
    end
    else
    begin
      if (busy_q > 0)
        busy_q <= busy_q - 1;
      if (act_q && !act)
      begin
        setup_q <= 8'h00;
        if (setup_q == 8'h40 || (setup_q == 8'h20 && d_q == 8'hd0))
        begin
          if (vpp_ok_in)
            busy_q <= BUSY_CYC;
          else
            sr_q <= sr_q | ((setup_q == 8'h40) ? 8'h18 : 8'h28);
        end
        else if (setup_q == 8'h20)
          sr_q <= sr_q | 8'h30;
        else if (d_q == 8'h40 || d_q == 8'h20)
          setup_q <= d_q;
        else if (d_q == FRG_CMD_CLEAR_STATUS)
          sr_q <= 8'h00;
        if (d_q == FRG_CMD_READ_ARRAY && setup_q == 8'h00)
          stat_q <= 1'b0;
        else
          stat_q <= 1'b1;
      end
    end
    // Released bus shows a moving pattern, not a held value
    if (on && !pins_in.chip_select_n && !pins_in.output_enable_n)
      data_out <= stat_q ? {8'h00, ready_busy_out, sr_q[6:0]} : ARRAY_WORD;
    else
      data_out <= ~data_out;
  end
endmodule : frg_flash_model

// ### flash_ready_busy_power_guard_tb.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module flash_ready_busy_power_guard_tb;
  import frg_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic vpp_ok = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic [15:0] rdata_out;
  logic [15:0] flash_q;
  logic [15:0] bus;
  logic [15:0] v;
  logic rb;
  frg_pins_s pins;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  always #4 mclk_in = ~mclk_in;
  // Host drives the bus while its enable is up
  assign bus = pins.data_oe ? pins.data : flash_q;
  frg_host frg_host_i(.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .ready_busy_in(rb), .data_in(bus), .pins_out(pins));
  frg_flash_model frg_flash_model_i(.mclk_in(mclk_in), .pins_in(pins),
    .vpp_ok_in(vpp_ok), .ready_busy_out(rb), .data_out(flash_q));
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task finish_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask : rd
  // Write one command word, then poll until it has gone out
  task cmd(input logic [15:0] d);
    wr(FRG_REG_CMD, d);
    repeat (50)
    begin
      rd(FRG_REG_STAT);
      if (v[FRG_ST_CMDPEND] === 1'b0)
        break;
    end
    // Pending clears at issue; the flash acts on the word five edges later
    repeat (6) @(posedge mclk_in);
  endtask : cmd
  // First read fetches the flash word, the second returns it
  task fst(input logic [15:0] exp);
    rd(FRG_REG_FSTAT);
    repeat (80) @(posedge mclk_in);
    rd(FRG_REG_FSTAT);
    check("flash word", v, exp);
  endtask : fst
  task wait_rdy;
    repeat (200)
    begin
      rd(FRG_REG_STAT);
      if (v[FRG_ST_BUSY] === 1'b0)
        break;
    end
  endtask : wait_rdy
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Hang guard, well above the expected run length
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      finish_test;
    end
  end
  initial
  begin
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    check("pin in pd", {15'h0000, rb}, 16'h0001);
    wr(FRG_REG_CTRL, 16'h0000);
    rd(FRG_REG_STAT);
    check("stat waking", v, 16'h0000);
    repeat (130) @(posedge mclk_in);
    fst(16'h5a3c);
    rd(FRG_REG_STAT);
    check("stat awake", v, 16'h000c);
    cmd(16'h0070);
    fst(16'h0080);
    rd(FRG_REG_STAT);
    check("need read array", {15'h0000, v[FRG_ST_NEEDRA]}, 16'h0001);
    // Word write: pin low while busy, status busy agrees
    cmd(16'h0040);
    cmd(16'h1234);
    check("pin busy", {15'h0000, rb}, 16'h0000);
    rd(FRG_REG_STAT);
    check("stat busy", {15'h0000, v[FRG_ST_BUSY]}, 16'h0001);
    rd(FRG_REG_CMD);
    check("cmd word", v, 16'h1234);
    wait_rdy;
    check("pin done", {15'h0000, rb}, 16'h0001);
    check("stat done", {15'h0000, v[FRG_ST_DONE]}, 16'h0001);
    rd(FRG_REG_STAT);
    check("done cleared", {15'h0000, v[FRG_ST_DONE]}, 16'h0000);
    // A lone confirm must not start anything
    cmd(16'h00d0);
    check("lone confirm", {15'h0000, rb}, 16'h0001);
    // Supply errors set flags that accumulate until cleared
    vpp_ok <= 1'b0;
    cmd(16'h0020);
    cmd(16'h00d0);
    fst(16'h00a8);
    cmd(16'h0040);
    cmd(16'h0000);
    fst(16'h00b8);
    cmd(FRG_CMD_CLEAR_STATUS);
    fst(16'h0080);
    vpp_ok <= 1'b1;
    // Power-down in mid-write aborts, then the sequence is reissued
    cmd(16'h0040);
    cmd(16'h0000);
    wr(FRG_REG_CTRL, 16'h0001);
    repeat (2) @(posedge mclk_in);
    check("pin abort", {15'h0000, rb}, 16'h0000);
    repeat (30) @(posedge mclk_in);
    check("pin deep pd", {15'h0000, rb}, 16'h0001);
    rd(FRG_REG_STAT);
    check("abort flag", {15'h0000, v[FRG_ST_ABORT]}, 16'h0001);
    rd(FRG_REG_CTRL);
    check("pd request", v, 16'h0001);
    wr(FRG_REG_CTRL, 16'h0000);
    repeat (130) @(posedge mclk_in);
    fst(16'h5a3c);
    rd(FRG_REG_STAT);
    check("stat rewake", v, 16'h001c);
    cmd(16'h0040);
    cmd(16'h0000);
    wait_rdy;
    rd(FRG_REG_STAT);
    check("abort cleared", {15'h0000, v[FRG_ST_ABORT]}, 16'h0000);
    fst(16'h0080);
    finish_test;
  end
endmodule : flash_ready_busy_power_guard_tb
